// ### design/acc_top.sv
// converter clock configuration, conversion sequencing and apb register file
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module acc_top #(
  parameter logic [acc_pkg::DIV_CNT_W-1:0] ASYNC_DIV = acc_pkg::ASYNC_DIV_DEFAULT
) (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // analog front end
  input wire logic [9:0] ANALOG_RESULT_I,
  input wire logic STOP_MODE_I,
  output logic [4:0] CHANNEL_SEL_O,
  output logic SAMPLE_HOLD_O,
  output logic CONVERTER_ON_O,
  output logic LOW_POWER_O,
  // interrupt
  output logic IRQ_O
);

  // register state
  logic [7:0] clk_cfg_reg;
  logic [7:0] clk_cfg_next;
  logic [6:0] ctrl_reg;
  logic [6:0] ctrl_next;
  logic conversion_complete_flag_reg;
  logic conversion_complete_flag_next;
  logic [acc_pkg::RES_W-1:0] result_reg;
  logic [acc_pkg::RES_W-1:0] sample_reg;
  logic [acc_pkg::IRQ_W-1:0] irq_status_reg;
  logic [acc_pkg::IRQ_W-1:0] irq_status_next;
  logic [acc_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [acc_pkg::IRQ_W-1:0] irq_mask_next;
  logic irq_reg;
  // bus state
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rdata;
  logic [9:0] bus_idx;
  logic bus_access;
  logic bus_done;
  logic wr_done;
  logic rd_done;
  logic known_idx;
  logic ctrl_write;
  // sequencer state
  acc_pkg::acc_seq_t seq_reg;
  acc_pkg::acc_seq_t seq_next;
  logic [acc_pkg::CYC_W-1:0] tick_cnt_reg;
  logic [acc_pkg::CYC_W-1:0] tick_cnt_next;
  logic [acc_pkg::CYC_W-1:0] sample_len;
  logic [acc_pkg::CYC_W-1:0] convert_len;
  logic busy_reg;
  logic sample_hold_reg;
  logic restart_reg;
  logic tick;
  logic run;
  logic start_req;
  logic abort_req;
  logic conv_done;
  logic capture;

  // bus decode
  assign bus_idx = PADDR_I[11:2];
  assign bus_access = PSEL_I && PENABLE_I;
  assign bus_done = bus_access && pready_reg;
  assign wr_done = bus_done && PWRITE_I;
  assign rd_done = bus_done && !PWRITE_I;
  assign ctrl_write = wr_done && (bus_idx == acc_pkg::IDX_CTRL);
  assign known_idx = (bus_idx == acc_pkg::IDX_IRQ_STATUS) || (bus_idx == acc_pkg::IDX_IRQ_MASK)
    || (bus_idx == acc_pkg::IDX_CTRL) || (bus_idx == acc_pkg::IDX_RESULT)
    || (bus_idx == acc_pkg::IDX_CLK_CFG);

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= bus_access && !pready_reg;
    end
  end

  // unknown index answers with an error
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= bus_access && !pready_reg && !known_idx;
    end
  end

  // read data stands while ready is high
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      prdata_reg <= 32'h0000_0000;
    end else if (bus_access && !pready_reg && !PWRITE_I) begin
      prdata_reg <= rdata;
    end
  end

  // read mux
  always_comb begin
    rdata = 32'h0000_0000;
    if (bus_idx == acc_pkg::IDX_IRQ_STATUS) begin
      rdata[acc_pkg::IRQ_W-1:0] = irq_status_reg;
    end
    if (bus_idx == acc_pkg::IDX_IRQ_MASK) begin
      rdata[acc_pkg::IRQ_W-1:0] = irq_mask_reg;
    end
    if (bus_idx == acc_pkg::IDX_CTRL) begin
      rdata[$bits(ctrl_reg)-1:0] = ctrl_reg;
      rdata[acc_pkg::CTRL_CONVERSION_COMPLETE_FLAG] = conversion_complete_flag_reg;
    end
    if (bus_idx == acc_pkg::IDX_RESULT) begin
      rdata[acc_pkg::RES_W-1:0] = result_reg;
    end
    if (bus_idx == acc_pkg::IDX_CLK_CFG) begin
      rdata[$bits(clk_cfg_reg)-1:0] = clk_cfg_reg;
    end
  end

  // clock register: format high bit never stored
  always_comb begin
    clk_cfg_next = clk_cfg_reg;
    if (wr_done && (bus_idx == acc_pkg::IDX_CLK_CFG)) begin
      clk_cfg_next = PWDATA_I[$bits(clk_cfg_reg)-1:0];
      clk_cfg_next[acc_pkg::CFG_FMT_HI] = 1'b0;
    end
  end
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      clk_cfg_reg <= acc_pkg::CFG_RESET;
    end else begin
      clk_cfg_reg <= clk_cfg_next;
    end
  end

  // control register: completion bit is not writable
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_write) begin
      ctrl_next = PWDATA_I[$bits(ctrl_reg)-1:0];
    end
  end
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ctrl_reg <= acc_pkg::CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // interrupt mask
  always_comb begin
    irq_mask_next = irq_mask_reg;
    if (wr_done && (bus_idx == acc_pkg::IDX_IRQ_MASK)) begin
      irq_mask_next = PWDATA_I[acc_pkg::IRQ_W-1:0];
    end
  end
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      irq_mask_reg <= acc_pkg::IRQ_RESET;
    end else begin
      irq_mask_reg <= irq_mask_next;
    end
  end

  // sticky status: write one to clear, a new event wins
  always_comb begin
    irq_status_next = irq_status_reg;
    if (wr_done && (bus_idx == acc_pkg::IDX_IRQ_STATUS)) begin
      irq_status_next = irq_status_reg & ~PWDATA_I[acc_pkg::IRQ_W-1:0];
    end
    if (conv_done) begin
      irq_status_next[acc_pkg::IRQ_DONE] = 1'b1;
      if (conversion_complete_flag_reg) begin
        irq_status_next[acc_pkg::IRQ_OVERRUN] = 1'b1;
      end
    end
  end
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      irq_status_reg <= acc_pkg::IRQ_RESET;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  // level interrupt from the settled status and mask
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_next & irq_mask_next);
    end
  end

  // completion flag: set wins over a clear in the same cycle
  always_comb begin
    conversion_complete_flag_next = conversion_complete_flag_reg;
    if (start_req || (rd_done && (bus_idx == acc_pkg::IDX_RESULT))) begin
      conversion_complete_flag_next = 1'b0;
    end
    if (conv_done) begin
      conversion_complete_flag_next = 1'b1;
    end
  end
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      conversion_complete_flag_reg <= 1'b0;
    end else begin
      conversion_complete_flag_reg <= conversion_complete_flag_next;
    end
  end

  // start, restart and abort requests
  assign start_req = (ctrl_write && (PWDATA_I[acc_pkg::CHAN_W-1:0] != acc_pkg::CHAN_OFF))
    || restart_reg;
  assign abort_req = ctrl_write && (PWDATA_I[acc_pkg::CHAN_W-1:0] == acc_pkg::CHAN_OFF);
  // phase lengths in converter clocks
  assign sample_len = acc_pkg::SAMPLE_CYC
    + (clk_cfg_reg[acc_pkg::CFG_LONG] ? acc_pkg::LONG_EXTRA_CYC : '0);
  assign convert_len = acc_pkg::CONV_BASE_CYC - acc_pkg::SAMPLE_CYC
    + (clk_cfg_reg[acc_pkg::CFG_ASYNC] ? acc_pkg::ASYNC_EXTRA_CYC : '0);
  // converter clock halts in stop unless the async source runs
  assign run = busy_reg && (!STOP_MODE_I || clk_cfg_reg[acc_pkg::CFG_ASYNC]);

  // conversion sequencer
  always_comb begin
    seq_next = seq_reg;
    tick_cnt_next = tick_cnt_reg;
    conv_done = 1'b0;
    capture = 1'b0;
    if (abort_req) begin
      seq_next = acc_pkg::SEQ_IDLE;
      tick_cnt_next = '0;
    end else if (start_req) begin
      seq_next = acc_pkg::SEQ_SAMPLE;
      tick_cnt_next = '0;
    end else begin
      unique case (seq_reg)
        acc_pkg::SEQ_IDLE: begin
          tick_cnt_next = '0;
        end
        acc_pkg::SEQ_SAMPLE: begin
          if (tick && (tick_cnt_reg == sample_len - 6'h01)) begin
            seq_next = acc_pkg::SEQ_CONVERT;
            tick_cnt_next = '0;
            capture = 1'b1;
          end else if (tick) begin
            tick_cnt_next = tick_cnt_reg + 6'h01;
          end
        end
        acc_pkg::SEQ_CONVERT: begin
          if (tick && (tick_cnt_reg == convert_len - 6'h01)) begin
            seq_next = acc_pkg::SEQ_IDLE;
            tick_cnt_next = '0;
            conv_done = 1'b1;
          end else if (tick) begin
            tick_cnt_next = tick_cnt_reg + 6'h01;
          end
        end
        default: begin
          seq_next = acc_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      seq_reg <= acc_pkg::SEQ_IDLE;
      tick_cnt_reg <= '0;
    end else begin
      seq_reg <= seq_next;
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  // front-end strobes aligned with the sequencer state
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      busy_reg <= 1'b0;
      sample_hold_reg <= 1'b0;
    end else begin
      busy_reg <= (seq_next != acc_pkg::SEQ_IDLE);
      sample_hold_reg <= (seq_next == acc_pkg::SEQ_SAMPLE);
    end
  end

  // continuous mode: one idle cycle, then the next conversion
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= conv_done && ctrl_reg[acc_pkg::CTRL_CONT] && !ctrl_write;
    end
  end

  // pin level held at the end of the sample phase
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sample_reg <= acc_pkg::RES_RESET;
    end else if (capture) begin
      sample_reg <= ANALOG_RESULT_I;
    end
  end

  // right-justified result only, ten or eight bits
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      result_reg <= acc_pkg::RES_RESET;
    end else if (conv_done) begin
      result_reg <= clk_cfg_reg[acc_pkg::CFG_FMT_LO] ? sample_reg
        : (sample_reg >> acc_pkg::SHORT_DROP);
    end
  end

  // converter clock: two divider bits only, no divide by six
  acc_tick_gen #(
    .ASYNC_DIV(ASYNC_DIV)
  ) u_tick_gen (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RESET_N_I),
    .run_i(run),
    .use_async_i(clk_cfg_reg[acc_pkg::CFG_ASYNC]),
    .alt_clk_i(clk_cfg_reg[acc_pkg::CFG_ICLK]),
    .div_sel_i(clk_cfg_reg[acc_pkg::CFG_DIV_HI:acc_pkg::CFG_DIV_LO]),
    .tick_o(tick)
  );

  // outputs straight from flip-flops
  assign PRDATA_O = prdata_reg;
  assign PREADY_O = pready_reg;
  assign PSLVERR_O = pslverr_reg;
  assign CHANNEL_SEL_O = ctrl_reg[acc_pkg::CHAN_W-1:0];
  assign SAMPLE_HOLD_O = sample_hold_reg;
  assign CONVERTER_ON_O = busy_reg;
  assign LOW_POWER_O = clk_cfg_reg[acc_pkg::CFG_LOW_POWER];
  assign IRQ_O = irq_reg;
endmodule

// ### include/acc_pkg.sv
// shared constants and types of the converter clock and conversion control block
package acc_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h03A;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h03B;
  localparam logic [9:0] IDX_CTRL = 10'h03C;
  localparam logic [9:0] IDX_RESULT = 10'h03D;
  localparam logic [9:0] IDX_CLK_CFG = 10'h03F;

  // converter_clock_config fields
  localparam int CFG_LOW_POWER = 7;
  localparam int CFG_DIV_HI = 6;
  localparam int CFG_DIV_LO = 5;
  localparam int CFG_ICLK = 4;
  localparam int CFG_FMT_HI = 3;
  localparam int CFG_FMT_LO = 2;
  localparam int CFG_LONG = 1;
  localparam int CFG_ASYNC = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // control register fields
  localparam int CTRL_CONVERSION_COMPLETE_FLAG = 7;
  localparam int CTRL_CONVERSION_INTERRUPT_ENABLE = 6;
  localparam int CTRL_CONT = 5;
  localparam int CHAN_W = 5;
  localparam logic [CHAN_W-1:0] CHAN_OFF = 5'h1F;
  localparam logic [6:0] CTRL_RESET = 7'h1F;

  // interrupt status and mask bits
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVERRUN = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // result
  localparam int RES_W = 10;
  localparam logic [RES_W-1:0] RES_RESET = 10'h000;
  localparam int SHORT_DROP = 2;

  // conversion length in converter clocks: 21 to 44
  localparam int CYC_W = 6;
  localparam logic [CYC_W-1:0] CONV_BASE_CYC = 6'h15;
  localparam logic [CYC_W-1:0] LONG_EXTRA_CYC = 6'h14;
  localparam logic [CYC_W-1:0] ASYNC_EXTRA_CYC = 6'h03;
  localparam logic [CYC_W-1:0] SAMPLE_CYC = 6'h04;

  // converter clock sources
  localparam int DIV_CNT_W = 4;
  localparam logic [DIV_CNT_W-1:0] ASYNC_DIV_DEFAULT = 4'h4;
  localparam logic [1:0] ALT_CLK_SHIFT = 2'h1;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_SAMPLE,
    SEQ_CONVERT
  } acc_seq_t;

endpackage

// ### design/acc_tick_gen.sv
// converter clock tick generator: divided bus clock or internal asynchronous source
`timescale 1ns/1ps
`default_nettype none

module acc_tick_gen #(
  parameter logic [acc_pkg::DIV_CNT_W-1:0] ASYNC_DIV = acc_pkg::ASYNC_DIV_DEFAULT
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // source selection
  input wire logic run_i,
  input wire logic use_async_i,
  input wire logic alt_clk_i,
  input wire logic [1:0] div_sel_i,
  // tick
  output logic tick_o
);

  logic [acc_pkg::DIV_CNT_W-1:0] cnt_reg;
  logic [acc_pkg::DIV_CNT_W-1:0] limit;
  logic [2:0] shift;

  // divide by 1, 2, 4 or 8, doubled on the alternate source; no divide by six
  always_comb begin
    shift = {1'b0, div_sel_i} + (alt_clk_i ? {1'b0, acc_pkg::ALT_CLK_SHIFT} : 3'h0);
    if (use_async_i) begin
      limit = ASYNC_DIV - 4'h1;
    end else begin
      limit = 4'(({1'b0, 4'h1} << shift) - 5'h01);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
    end else if (!run_i || cnt_reg >= limit) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= run_i && (cnt_reg >= limit);
    end
  end

endmodule

`default_nettype wire

// ### dv/acc_pin_model.sv
// analog pin model feeding converter levels
`timescale 1ns/1ps
`default_nettype none
module acc_pin_model (
  // clock
  input wire logic clk_i,
  // level the bench puts on the pin
  input wire logic [9:0] set_i,
  // level seen by the converter
  output logic [9:0] level_o
);
  // pin kept as input, so only the analog source moves it
  initial level_o = 10'h2A5;
  always @(posedge clk_i) level_o <= set_i;
endmodule
`default_nettype wire

// ### dv/acc_monitor.sv
// port checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module acc_monitor (
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic PREADY_O,
  input wire logic STOP_MODE_I,
  input wire logic [4:0] CHANNEL_SEL_O,
  input wire logic SAMPLE_HOLD_O,
  input wire logic CONVERTER_ON_O,
  input wire logic LOW_POWER_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  wire logic wr_done = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
  wire logic cw = wr_done && PADDR_I == 12'h0FC;
  wire logic ctrl_wr = wr_done && PADDR_I == 12'h0F0;
  apb_answer_a: assert property (PSEL_I && PENABLE_I |-> ##[0:15] PREADY_O)
    else $error("no ready");
  lp_follow_a: assert property (cw |=> LOW_POWER_O == $past(PWDATA_I[7]))
    else $error("low power not set");
  lp_hold_a: assert property (!cw |=> $stable(LOW_POWER_O))
    else $error("low power moved");
  ch_hold_a: assert property (!ctrl_wr |=> $stable(CHANNEL_SEL_O))
    else $error("channel moved without a write");
  sample_first_a: assert property ($rose(CONVERTER_ON_O) |-> SAMPLE_HOLD_O)
    else $error("conversion did not open with sampling");
  conv_min_a: assert property (disable iff (!RESET_N_I || ctrl_wr)
      $rose(CONVERTER_ON_O) |-> CONVERTER_ON_O [*8])
    else $error("conversion too short");
  conv_end_a: assert property (disable iff (!RESET_N_I || STOP_MODE_I || ctrl_wr)
      $rose(CONVERTER_ON_O) |-> ##[21:1000] !CONVERTER_ON_O)
    else $error("conversion did not end");
endmodule
bind acc_top acc_monitor u_mon (.*);
`default_nettype wire

// ### dv/tb_acc_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_acc_top;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, irq, lp, pready;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, q, prdata;
  logic [9:0] lvl, lvl_set = 10'h000;
  logic [7:0] v;
  int bad_count = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  acc_pin_model u_pin (.clk_i(clk), .set_i(lvl_set), .level_o(lvl));
  function automatic logic [7:0] cfg_exp(input logic [7:0] w);
    return w & ~(8'h01 << acc_pkg::CFG_FMT_HI);
  endfunction
  function automatic logic [9:0] res_exp(input logic [9:0] l, input logic full);
    return full ? l : {2'h0, l[9:2]};
  endfunction
  acc_top DUT (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(), .ANALOG_RESULT_I(lvl), .STOP_MODE_I(1'b0), .CHANNEL_SEL_O(),
    .SAMPLE_HOLD_O(), .CONVERTER_ON_O(), .LOW_POWER_O(lp), .IRQ_O(irq));
  task automatic bus(input logic w, input logic [9:0] i, input logic [31:0] d);
    psel <= 1;
    pwr <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge clk) pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    q = $urandom(62087);
    repeat (20) @(posedge clk);
    rst_n <= 1;
    bus(0, acc_pkg::IDX_CLK_CFG, 0);
    chk("cfg reset", q, 0);
    for (int k = 0; k < 6; k++) begin
      v = k < 2 ? {8{k[0]}} : 8'($urandom);
      bus(1, acc_pkg::IDX_CLK_CFG, {24'h0, v});
      chk("low power", lp, v[7]);
      bus(0, acc_pkg::IDX_CLK_CFG, 0);
      chk("cfg", q, cfg_exp(v));
    end
    $display("cfg test ended");
    bus(1, acc_pkg::IDX_CLK_CFG, 0);
    bus(1, acc_pkg::IDX_IRQ_MASK, 1);
    bus(1, acc_pkg::IDX_CTRL, 32'h9F);
    bus(0, acc_pkg::IDX_CTRL, 0);
    chk("flag", q[7], 0);
    chk("ctrl", q[6:0], 7'h1F);
    lvl_set <= 10'($urandom);
    bus(1, acc_pkg::IDX_CTRL, 32'h80);
    repeat (900) if (irq !== 1'b1) @(posedge clk);
    chk("irq", irq, 1);
    bus(0, acc_pkg::IDX_CTRL, 0);
    chk("flag set", q[7], 1);
    bus(0, acc_pkg::IDX_RESULT, 0);
    chk("result", q, res_exp(lvl_set, 1'b0));
    bus(0, acc_pkg::IDX_CTRL, 0);
    chk("flag clear", q[7], 0);
    bus(0, acc_pkg::IDX_IRQ_STATUS, 0);
    chk("done", q[0], 1);
    bus(1, acc_pkg::IDX_IRQ_STATUS, 1);
    chk("irq clear", irq, 0);
    $display("conversion test ended");
    close_out();
  end
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
